// ==== rct_reset_clock.sv ====
// Function
// - Mode pins are captured while hard reset is asserted and set pll and clock factors.
// - The three mode pins encode eight basic configurations.
// - With reset config select and four data pins, 5 further configurations exist, 0001_000 to 0001_100.
// - A new configuration takes effect only after power-on reset, not on hard reset alone.
// - Each input clock cycle has four ticks, first at the rising and third at the falling edge.
// - For integer ratios the second and fourth ticks sit at one and three quarters.
// - At ratio 2.5 they sit at 3/10 and 8/10, at ratio 3.5 at 4/14 and 11/14.
// - User machine outputs change on the tick that programming selects.
// - Sdram and chip-select machine outputs change only on the input clock rising edge.
// - Other bus and system outputs launch from the input clock rising edge.
// - Basic mode patterns 000 to 111 follow the default mode table.
// - Extended code is high field then mode pins, 0001_000 giving cpm 2 and core 4.
// - The system and local buses run at the input clock frequency in every mode.
`timescale 1ns/10ps
`include "rct_cfg.svh"

module rct_reset_clock #(
    parameter int CNT_W = 8,
    parameter int UPM_W = 8,
    parameter int SDR_W = 8,
    parameter int BUS_W = 8
) (
    // clock and control
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // reset and strap pins
    input wire logic input_clock_i,
    input wire logic hard_reset_i,
    input wire logic power_on_reset_i,
    input wire logic reset_config_select_i,
    input wire logic [2:0] clock_mode_pins_i,
    input wire logic [3:0] high_clock_mode_field_i,
    // machine outputs to be launched
    input wire logic [UPM_W-1:0] upm_next_i,
    input wire logic [1:0] upm_tick_sel_i,
    input wire logic [SDR_W-1:0] sdram_general_chip_select_machine_next_i,
    input wire logic [BUS_W-1:0] bus_next_i,
    // configuration and ticks
    output rct_pkg::rct_cfg_type active_cfg_o,
    output rct_pkg::rct_ticks_type ticks_o,
    output logic bus_clock_o,
    // launched outputs
    output logic [UPM_W-1:0] upm_o,
    output logic [SDR_W-1:0] sdram_general_chip_select_machine_o,
    output logic [BUS_W-1:0] bus_o
);

    localparam int PW = CNT_W + 8;
    localparam logic [31:0] BASIC_CPM = `RCT_BASIC_CPM_X2;
    localparam logic [39:0] BASIC_CORE = `RCT_BASIC_CORE_X2;

    if (CNT_W < 4 || CNT_W > 16) begin : g_cnt_check
        $error("CNT_W must be 4 to 16");
    end
    if (UPM_W < 1 || SDR_W < 1 || BUS_W < 1) begin : g_width_check
        $error("output widths must be positive");
    end

    // two-stage synchronisers for every pin
    logic [10:0] pin_meta_r;
    logic [10:0] pin_sync_r;
    wire logic [10:0] pin_raw = {input_clock_i, hard_reset_i, power_on_reset_i,
        reset_config_select_i, clock_mode_pins_i, high_clock_mode_field_i};

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pin_meta_r <= 11'h000;
            pin_sync_r <= 11'h000;
        end else if (ce_i) begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
        end
    end

    wire logic clk_s = pin_sync_r[10];
    wire logic hrst_s = pin_sync_r[9];
    wire logic por_s = pin_sync_r[8];
    wire logic rcs_s = pin_sync_r[7];
    wire logic [2:0] mode_s = pin_sync_r[6:4];
    wire logic [3:0] high_s = pin_sync_r[3:0];

    // strap capture and configuration decode
    rct_pkg::rct_code_type sample_r;
    rct_pkg::rct_cfg_type active_r;
    logic por_d_r;

    // without reset config select the high field reads as zero: basic modes only
    wire logic [3:0] high_pick = rcs_s ? high_s : 4'h0;
    wire logic por_fall = por_d_r & ~por_s;
    wire logic is_basic = (sample_r.high_clock_mode_field == 4'h0);
    wire logic is_ext = (sample_r.high_clock_mode_field == `RCT_EXT_HIGH)
        && (sample_r.clock_mode_pins <= `RCT_EXT_LAST_MODE);
    wire logic [3:0] basic_cpm = BASIC_CPM[{sample_r.clock_mode_pins, 2'b00} +: 4];
    wire logic [4:0] basic_core = BASIC_CORE[sample_r.clock_mode_pins * 5 +: 5];
    wire logic [4:0] ext_core = `RCT_EXT_CORE_BASE_X2
        + {1'b0, sample_r.clock_mode_pins, 1'b0};
    rct_pkg::rct_cfg_type dec_cfg;
    assign dec_cfg.code = sample_r;
    assign dec_cfg.cpm_mult_x2 = is_basic ? basic_cpm : (is_ext ? `RCT_EXT_CPM_X2 : 4'h0);
    assign dec_cfg.core_mult_x2 = is_basic ? basic_core : (is_ext ? ext_core : 5'h00);
    assign dec_cfg.valid = is_basic | is_ext;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sample_r <= '0;
            por_d_r <= 1'b0;
            active_r.code <= `RCT_RST_CODE;
            active_r.cpm_mult_x2 <= `RCT_RST_CPM_X2;
            active_r.core_mult_x2 <= `RCT_RST_CORE_X2;
            active_r.valid <= 1'b1;
        end else if (ce_i) begin
            por_d_r <= por_s;
            if (hrst_s) begin
                sample_r <= {high_pick, mode_s};
            end
            if (por_fall) begin
                active_r <= dec_cfg;
            end
        end
    end

    // tick generation, period measured in mclk cycles
    logic clk_d_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] per_r;
    logic fired2_r;
    logic fired4_r;
    logic rise_seen_r;
    rct_pkg::rct_ticks_type ticks_r;

    wire logic rise = clk_s & ~clk_d_r;
    wire logic fall = ~clk_s & clk_d_r;
    wire logic is_r25 = (active_r.cpm_mult_x2 == `RCT_RATIO_X2_R25);
    wire logic is_r35 = (active_r.cpm_mult_x2 == `RCT_RATIO_X2_R35);
    wire logic [7:0] pos2 = is_r25 ? `RCT_POS2_R25 :
        (is_r35 ? `RCT_POS2_R35 : `RCT_POS2_INT);
    wire logic [7:0] pos4 = is_r25 ? `RCT_POS4_R25 :
        (is_r35 ? `RCT_POS4_R35 : `RCT_POS4_INT);
    wire logic [PW-1:0] now_scaled = PW'(cnt_r) * PW'(`RCT_FRAC_DEN);
    wire logic [PW-1:0] pos2_scaled = PW'(pos2) * PW'(per_r);
    wire logic [PW-1:0] pos4_scaled = PW'(pos4) * PW'(per_r);
    // a zero period (fewer than two rises seen yet) gives no second or fourth tick
    wire logic per_ok = (per_r != '0);
    wire logic hit2 = per_ok & ~fired2_r & ~rise & (now_scaled >= pos2_scaled);
    wire logic hit4 = per_ok & ~fired4_r & ~rise & (now_scaled >= pos4_scaled);
    wire logic cnt_max = (cnt_r == {CNT_W{1'b1}});
    rct_pkg::rct_ticks_type ticks_nxt;
    assign ticks_nxt.tick_first = rise;
    assign ticks_nxt.tick_second = hit2;
    assign ticks_nxt.tick_third = fall;
    assign ticks_nxt.tick_fourth = hit4;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            clk_d_r <= 1'b0;
            cnt_r <= '0;
            per_r <= '0;
            fired2_r <= 1'b0;
            fired4_r <= 1'b0;
            rise_seen_r <= 1'b0;
            ticks_r <= '0;
        end else if (ce_i) begin
            clk_d_r <= clk_s;
            ticks_r <= ticks_nxt;
            if (rise) begin
                cnt_r <= '0;
                rise_seen_r <= 1'b1;
                // the count before the first rise is only a partial period
                if (rise_seen_r) begin
                    per_r <= cnt_max ? cnt_r : cnt_r + 1'b1;
                end
                fired2_r <= 1'b0;
                fired4_r <= 1'b0;
            end else begin
                if (!cnt_max) begin
                    cnt_r <= cnt_r + 1'b1;
                end
                fired2_r <= fired2_r | hit2;
                fired4_r <= fired4_r | hit4;
            end
        end
    end

    // output launch
    logic [UPM_W-1:0] upm_r;
    logic [SDR_W-1:0] sdram_r;
    logic [BUS_W-1:0] bus_r;
    logic bus_clk_r;

    wire logic [3:0] tick_vec = {ticks_nxt.tick_fourth, ticks_nxt.tick_third,
        ticks_nxt.tick_second, ticks_nxt.tick_first};
    wire logic upm_go = tick_vec[upm_tick_sel_i];

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            upm_r <= '0;
            sdram_r <= '0;
            bus_r <= '0;
            bus_clk_r <= 1'b0;
        end else if (ce_i) begin
            bus_clk_r <= clk_s;
            if (upm_go) begin
                upm_r <= upm_next_i;
            end
            if (rise) begin
                sdram_r <= sdram_general_chip_select_machine_next_i;
                bus_r <= bus_next_i;
            end
        end
    end

    assign active_cfg_o = active_r;
    assign ticks_o = ticks_r;
    assign bus_clock_o = bus_clk_r;
    assign upm_o = upm_r;
    assign sdram_general_chip_select_machine_o = sdram_r;
    assign bus_o = bus_r;

    a_first_on_rise: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && rise |=> ticks_r.tick_first)
        else $error("first tick missing after input clock rise");

    a_third_on_fall: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && fall |=> ticks_r.tick_third && !ticks_r.tick_first)
        else $error("third tick missing after input clock fall");

    a_fourth_after_second: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ticks_r.tick_fourth |-> fired2_r && !ticks_r.tick_first)
        else $error("fourth tick before second tick");

    a_cfg_hold_hard_reset: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !(ce_i && por_fall) |=> $stable(active_r))
        else $error("configuration changed without power-on reset");

    a_sample_in_hard_reset: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && hrst_s |=> sample_r.clock_mode_pins == $past(mode_s))
        else $error("mode pins not captured during hard reset");

    a_basic_mode_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && por_fall && sample_r == 7'h00
        |=> active_r.cpm_mult_x2 == 4'h6 && active_r.core_mult_x2 == 5'h08)
        else $error("basic mode 000 decoded wrongly");

    a_ext_mode_first: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && por_fall && sample_r == 7'h08
        |=> active_r.cpm_mult_x2 == 4'h4 && active_r.core_mult_x2 == 5'h08)
        else $error("extended mode 0001_000 decoded wrongly");

    a_sdram_on_rise: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $changed(sdram_r) |-> $past(rise) && $past(ce_i))
        else $error("sdram output moved off the rising edge");

    a_bus_on_rise: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $changed(bus_r) |-> $past(rise) && $past(ce_i))
        else $error("bus output moved off the rising edge");

    a_upm_on_tick: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $changed(upm_r) |-> $past(upm_go) && $past(ce_i))
        else $error("user machine output moved off its tick");

    a_bus_clock_copy: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ce_i |=> bus_clk_r == $past(clk_s))
        else $error("bus clock does not follow the input clock");

    a_first_restarts: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && rise |=> cnt_r == '0 && !fired2_r && !fired4_r)
        else $error("tick phase not realigned on input clock rise");

    a_period_held: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !(ce_i && rise) |=> $stable(per_r))
        else $error("period changed between input clock rises");

    a_ticks_no_clash: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !(ticks_r.tick_first && (ticks_r.tick_second || ticks_r.tick_fourth)))
        else $error("second or fourth tick on the rising edge");

    a_basic_no_select: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && hrst_s && !rcs_s |=> sample_r.high_clock_mode_field == 4'h0)
        else $error("high field taken without reset config select");

    a_valid_factors: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        active_r.valid |-> active_r.cpm_mult_x2 != 4'h0 && active_r.core_mult_x2 != 5'h00)
        else $error("valid configuration with a zero factor");

    a_ext_cpm_fixed: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        active_r.valid && active_r.code.high_clock_mode_field == `RCT_EXT_HIGH
        |-> active_r.cpm_mult_x2 == `RCT_EXT_CPM_X2)
        else $error("extended mode with wrong cpm factor");

    a_basic_mode_four: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && por_fall && sample_r == 7'h04
        |=> active_r.cpm_mult_x2 == 4'h4 && active_r.core_mult_x2 == 5'h05)
        else $error("basic mode 100 decoded wrongly");

    a_basic_mode_seven: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ce_i && por_fall && sample_r == 7'h07
        |=> active_r.cpm_mult_x2 == 4'h5 && active_r.core_mult_x2 == 5'h06)
        else $error("basic mode 111 decoded wrongly");

    a_ce_freeze: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !ce_i |=> $stable(active_r) && $stable(ticks_r) && $stable(upm_r)
        && $stable(sdram_r) && $stable(bus_r) && $stable(bus_clk_r))
        else $error("state moved while clock enable was low");

endmodule

// ==== rct_cfg.svh ====
`ifndef RCT_CFG_SVH
`define RCT_CFG_SVH

// clock rate of mclk_i
`define RCT_MCLK_HZ 10000000
// tick positions in 140ths of an input clock period
`define RCT_FRAC_DEN 8'h8c
`define RCT_POS2_INT 8'h23
`define RCT_POS4_INT 8'h69
`define RCT_POS2_R25 8'h2a
`define RCT_POS4_R25 8'h70
`define RCT_POS2_R35 8'h28
`define RCT_POS4_R35 8'h6e
// doubled pll ratios that move the ticks
`define RCT_RATIO_X2_R25 4'h5
`define RCT_RATIO_X2_R35 4'h7
// basic mode table, doubled factors, mode 7 in the top nibble
`define RCT_BASIC_CPM_X2 32'h5544_8866
// core table in 5-bit fields, mode 0 in bits 4:0
`define RCT_BASIC_CORE_X2 40'h31_4c55_2148
// extended family 0001_xxx
`define RCT_EXT_HIGH 4'h1
`define RCT_EXT_LAST_MODE 3'h4
`define RCT_EXT_CPM_X2 4'h4
`define RCT_EXT_CORE_BASE_X2 5'h08
// configuration after sys_rst_i
`define RCT_RST_CODE 7'h00
`define RCT_RST_CPM_X2 4'h6
`define RCT_RST_CORE_X2 5'h08

`endif

// ==== rct_pkg.sv ====
package rct_pkg;

    typedef struct packed {
        logic [3:0] high_clock_mode_field;
        logic [2:0] clock_mode_pins;
    } rct_code_type;

    typedef struct packed {
        rct_code_type code;
        logic [3:0] cpm_mult_x2;
        logic [4:0] core_mult_x2;
        logic valid;
    } rct_cfg_type;

    typedef struct packed {
        logic tick_first;
        logic tick_second;
        logic tick_third;
        logic tick_fourth;
    } rct_ticks_type;

endpackage

// ==== rct_board.sv ====
`timescale 1ns/10ps

module rct_board #(
    parameter int PER = 140
) (
    // clock
    input wire logic mclk_i,
    // reset and strap pins
    output logic input_clock_o,
    output logic hard_reset_o,
    output logic power_on_reset_o,
    output logic reset_config_select_o,
    output logic [2:0] clock_mode_pins_o,
    output logic [3:0] high_clock_mode_field_o
);
    int cnt = 0;

    initial begin
        input_clock_o = 1'b0;
        hard_reset_o = 1'b0;
        power_on_reset_o = 1'b0;
        reset_config_select_o = 1'b0;
        clock_mode_pins_o = 3'h5;
        high_clock_mode_field_o = 4'ha;
    end

    // free-running board oscillator, 50 percent duty
    always @(posedge mclk_i) begin
        #1;
        cnt = cnt + 1;
        if (cnt >= PER / 2) begin
            cnt = 0;
            input_clock_o = ~input_clock_o;
        end
    end

    task automatic strap(input logic [6:0] code, input logic with_por);
        @(posedge mclk_i);
        #1;
        reset_config_select_o = (code[6:3] != 4'h0);
        // data pins carry junk in basic modes, select low must mask it
        high_clock_mode_field_o = (code[6:3] != 4'h0) ? code[6:3] : {1'b1, code[2:0]};
        clock_mode_pins_o = code[2:0];
        hard_reset_o = 1'b1;
        power_on_reset_o = with_por;
        repeat (6) @(posedge mclk_i);
        #1;
        power_on_reset_o = 1'b0;
        // hard reset outlasts por so sampling stays covered
        repeat (2) @(posedge mclk_i);
        #1;
        hard_reset_o = 1'b0;
        @(posedge mclk_i);
        #1;
        // shared strap lines go elsewhere once released
        clock_mode_pins_o = ~code[2:0];
        high_clock_mode_field_o = ~code[6:3];
        reset_config_select_o = ~reset_config_select_o;
        repeat (4) @(posedge mclk_i);
    endtask
endmodule

// ==== reset_clock_config_and_ticks_tb.sv ====
`timescale 1ns/10ps

module reset_clock_config_and_ticks_tb;
    localparam int PER = 140;
    typedef struct packed {
        logic [7:0] user_programmable_machine;
        logic [1:0] sel;
        logic [7:0] sdr;
        logic [7:0] bus;
    } rct_note_type;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic input_clock_i, hard_reset_i, power_on_reset_i, reset_config_select_i;
    logic [2:0] clock_mode_pins_i;
    logic [3:0] high_clock_mode_field_i;
    logic [7:0] upm_next_i = 8'h00;
    logic [1:0] upm_tick_sel_i = 2'h0;
    logic [7:0] sdram_general_chip_select_machine_next_i = 8'h00;
    logic [7:0] bus_next_i = 8'h00;
    rct_pkg::rct_cfg_type active_cfg_o, cfg_prev;
    rct_pkg::rct_ticks_type ticks_o;
    logic bus_clock_o, bc_prev;
    logic [7:0] upm_o, sdram_general_chip_select_machine_o, bus_o, upm_prev, sdr_prev, bus_prev;
    rct_pkg::rct_cfg_type cfg_q[$];
    rct_note_type nq[$];
    rct_note_type nt;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int t1 = 0;
    int tb = 0;
    int d2 = 0;
    int exp_d2 = 0;
    int exp_d4 = 0;
    logic chk_en = 1'b0;
    logic [15:0] rnd = 16'd24833;
    logic [15:0] r1;
    logic ce_i = 1'b1;
    logic [28:0] snap;

    initial begin
        forever #50 mclk_i = ~mclk_i;
    end

    rct_board #(.PER(PER)) board (.mclk_i(mclk_i), .input_clock_o(input_clock_i),
        .hard_reset_o(hard_reset_i), .power_on_reset_o(power_on_reset_i),
        .reset_config_select_o(reset_config_select_i), .clock_mode_pins_o(clock_mode_pins_i),
        .high_clock_mode_field_o(high_clock_mode_field_i));

    rct_reset_clock DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .input_clock_i(input_clock_i), .hard_reset_i(hard_reset_i),
        .power_on_reset_i(power_on_reset_i), .reset_config_select_i(reset_config_select_i),
        .clock_mode_pins_i(clock_mode_pins_i), .high_clock_mode_field_i(high_clock_mode_field_i),
        .upm_next_i(upm_next_i), .upm_tick_sel_i(upm_tick_sel_i),
        .sdram_general_chip_select_machine_next_i(sdram_general_chip_select_machine_next_i), .bus_next_i(bus_next_i),
        .active_cfg_o(active_cfg_o), .ticks_o(ticks_o), .bus_clock_o(bus_clock_o),
        .upm_o(upm_o), .sdram_general_chip_select_machine_o(sdram_general_chip_select_machine_o), .bus_o(bus_o));

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic rct_pkg::rct_cfg_type exp_cfg(input logic [6:0] c);
        logic [3:0] comms_processor_module[8] = '{4'h6, 4'h6, 4'h8, 4'h8, 4'h4, 4'h4, 4'h5, 4'h5};
        logic [4:0] core[8] = '{5'h08, 5'h0a, 5'h08, 5'h0a, 5'h05, 5'h06, 5'h05, 5'h06};
        if (c[6:3] == 4'h0)
            return {c, comms_processor_module[c[2:0]], core[c[2:0]], 1'b1};
        if (c[6:3] == 4'h1 && c[2:0] <= 3'h4)
            return {c, 4'h4, 5'h08 + {1'b0, c[2:0], 1'b0}, 1'b1};
        return {c, 4'h0, 5'h00, 1'b0};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic tick_phase(input int p2, input int p4);
        exp_d2 = (p2 * PER + 139) / 140;
        exp_d4 = (p4 * PER + 139) / 140;
        repeat (3 * PER) @(posedge mclk_i);
        chk_en = 1'b1;
        repeat (3 * PER) @(posedge mclk_i);
        chk_en = 1'b0;
    endtask

    always @(posedge mclk_i) begin
        #1;
        r1 = lfsr(rnd);
        rnd = lfsr(r1);
        upm_next_i = r1[7:0];
        bus_next_i = r1[15:8];
        sdram_general_chip_select_machine_next_i = rnd[7:0];
        upm_tick_sel_i = rnd[9:8];
        nq.push_back({upm_next_i, upm_tick_sel_i, sdram_general_chip_select_machine_next_i, bus_next_i});
    end

    always @(negedge mclk_i) begin
        cyc++;
        if (cyc > 8000) begin
            err_total++;
            print_verdict();
        end
        if (nq.size() > 1)
            nt = nq.pop_front();
        if (!sys_rst_i && active_cfg_o !== cfg_prev) begin
            if (cfg_q.size() == 0)
                chk("active_cfg_change", 32'(cfg_prev), 32'(active_cfg_o));
            else
                chk("active_cfg", 32'(cfg_q.pop_front()), 32'(active_cfg_o));
        end
        if (chk_en) begin
            chk("bus_o", ticks_o.tick_first ? nt.bus : bus_prev, bus_o);
            chk("sdram_general_chip_select_machine_o", ticks_o.tick_first ? nt.sdr : sdr_prev, sdram_general_chip_select_machine_o);
            chk("upm_o", ticks_o[3 - nt.sel] ? nt.user_programmable_machine : upm_prev, upm_o);
            if (ticks_o.tick_first)
                chk("first_spacing", PER, cyc - t1);
            if (ticks_o.tick_second)
                chk("second_pos", exp_d2 + 1, cyc - t1);
            if (ticks_o.tick_third)
                chk("third_pos", PER / 2, cyc - t1);
            if (ticks_o.tick_fourth)
                chk("fourth_gap", exp_d4 - exp_d2, cyc - t1 - d2);
            if (bus_clock_o && !bc_prev)
                chk("bus_clock_period", PER, cyc - tb);
        end
        if (ticks_o.tick_first)
            t1 = cyc;
        if (ticks_o.tick_second)
            d2 = cyc - t1;
        if (bus_clock_o && !bc_prev)
            tb = cyc;
        bc_prev = bus_clock_o;
        cfg_prev = active_cfg_o;
        upm_prev = upm_o;
        sdr_prev = sdram_general_chip_select_machine_o;
        bus_prev = bus_o;
    end

    initial begin
        repeat (3) @(posedge mclk_i);
        #1;
        sys_rst_i = 1'b0;
        @(negedge mclk_i);
        chk("reset_cfg", {7'h00, 4'h6, 5'h08, 1'b1}, 32'(active_cfg_o));
        board.strap(7'h07, 1'b0);
        // unknown code first, so every step differs from its neighbour
        for (int i = 0; i < 14; i++) begin
            cfg_q.push_back(exp_cfg(i == 0 ? 7'h20 : 7'(i - 1)));
            board.strap(i == 0 ? 7'h20 : 7'(i - 1), 1'b1);
        end
        tick_phase(35, 105);
        cfg_q.push_back(exp_cfg(7'h06));
        board.strap(7'h06, 1'b1);
        tick_phase(42, 112);
        chk("cfg_queue_left", 0, cfg_q.size());
        // clock enable low must freeze the ticks, bus clock and launched outputs
        @(posedge mclk_i);
        #1;
        ce_i = 1'b0;
        @(negedge mclk_i);
        snap = {ticks_o, bus_clock_o, upm_o, sdram_general_chip_select_machine_o, bus_o};
        repeat (20) begin
            @(negedge mclk_i);
            chk("ce_freeze", 32'(snap), 32'({ticks_o, bus_clock_o, upm_o, sdram_general_chip_select_machine_o, bus_o}));
        end
        @(posedge mclk_i);
        #1;
        ce_i = 1'b1;
        print_verdict();
    end
endmodule
